// *** stc_regs.svh ***
// stc_regs.svh: offsets, fields, command codes and rate constants of the speed throttle
//------------------------------------------------------------------------------
// Notes on behaviour
// - normal rate is input clock divided by fifty
// - speed command comes from nibble four or a control register write
// - power-down and reset restore divide by fifty
// - commands 8..D select dividers 50,25,10,5,2.5,1
// - speed up only by swallowing pulses; bus normal
// - fast only for internal program memory fetches
// - idle serial bus shows continuous no-op fetches
// - observed instructions halt core during bus replay
// - listed control and undefined opcodes are re-fetched
// - keyboard and flag instructions run normal, no replay
// - reads re-fetched only for peripheral registers
// - writes replayed for peripherals, fast for memory
// - spare bits force normal until clean fetch
// - bit 12: this and next fetch normal
// - bit 13: re-fetch, execute normal, next normal
// - spare bits ignored on auto-normal instructions
//------------------------------------------------------------------------------
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
// register byte offsets
`define STC_CTRL_OFS 8'h00
`define STC_STAT_OFS 8'h04
// control field: speed command nibble
`define STC_CTRL_CMD_LSB 0
// status fields
`define STC_STAT_SPD_LSB 0
`define STC_STAT_SLOW_BIT 4
`define STC_STAT_HALT_BIT 5
// speed command codes
`define STC_CMD_N50 4'h8
`define STC_CMD_N25 4'h9
`define STC_CMD_N10 4'hA
`define STC_CMD_N5 4'hB
`define STC_CMD_N2P5 4'hC
`define STC_CMD_N1 4'hD
// dividers in half input cycles
`define STC_DIV2_N50 8'h64
`define STC_DIV2_N25 8'h32
`define STC_DIV2_N10 8'h14
`define STC_DIV2_N5 8'h0A
`define STC_DIV2_N2P5 8'h05
`define STC_DIV2_N1 8'h02
// bus ticks in one external instruction slot
`define STC_SLOT_TICKS 56
// axi responses
`define STC_RESP_OKAY 2'h0
`define STC_RESP_SLVERR 2'h2
`endif

// *** stc_pkg.sv ***
// stc_pkg.sv: types of the speed throttle
package stc_pkg;
   // selected core speed
   typedef enum logic [2:0] {SPD_N50, SPD_N25, SPD_N10, SPD_N5, SPD_N2P5, SPD_N1} stc_speed_t;
   // replay sequencer states
   typedef enum logic [1:0] {REP_IDLE, REP_ALIGN, REP_THIS, REP_NEXT} stc_rep_t;
   // word shown on the external serial bus
   typedef enum logic [1:0] {BUS_NOP, BUS_THIS, BUS_NEXT} stc_bus_sel_t;
endpackage

// *** stc_rate_if.sv ***
// stc_rate_if.sv: divider setting and tick between top and rate generator
`timescale 1ns/1ps
`default_nettype none
interface stc_rate_if;
   logic [7:0] div2; // divider in half input cycles
   logic tick; // one-cycle enable pulse
   modport gen (input div2, output tick);
   modport user (output div2, input tick);
endinterface
`default_nettype wire

// *** stc_rate_gen.sv ***
// stc_rate_gen.sv: pulse swallowing rate generator with half-cycle resolution
`timescale 1ns/1ps
`default_nettype none
module stc_rate_gen (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // rate port
   stc_rate_if.gen rate
);
   import stc_pkg::*;
   logic [7:0] acc_q; // accumulated half cycles
   logic [7:0] acc_d;
   logic [8:0] sum; // accumulator after this input cycle
   logic fire; // a core pulse passes this cycle
   logic stale; // remainder left over from a slower divider
   //------------------------------------------------------------------------------
   // accumulator
   //------------------------------------------------------------------------------
   assign sum = {1'b0, acc_q} + 9'h002;
   assign fire = sum >= {1'b0, rate.div2};
   // a remainder at or above the new divider would burst pulses, so restart from zero
   assign stale = acc_q >= rate.div2;
   assign acc_d = fire ? (stale ? 8'h00 : 8'(sum - {1'b0, rate.div2})) : sum[7:0];
   // tick is a flop so each pulse is one clean cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_q <= 8'h00;
         rate.tick <= 1'b0;
      end else begin
         acc_q <= acc_d;
         rate.tick <= fire;
      end
   end
endmodule
`default_nettype wire

// *** stc_top.sv ***
// stc_top.sv: core speed throttle with bus replay sequencer and register slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "stc_regs.svh"
module stc_top #(
   parameter int SLOT_TICKS = `STC_SLOT_TICKS
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // decoded fetch from the core
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_internal,
   input wire logic periph_reg,
   input wire logic [3:0] cmd_nibble,
   input wire logic power_down,
   // clock enables and bus control
   output logic core_ce,
   output logic bus_ce,
   output logic core_halt,
   output stc_pkg::stc_bus_sel_t bus_word_sel
);
   import stc_pkg::*;
   //------------------------------------------------------------------------------
   // opcode fields
   //------------------------------------------------------------------------------
   logic [3:0] hi; // opcode bits 9:6
   logic [3:0] mid; // opcode bits 5:2
   logic cls0; // class zero opcode
   logic [1:0] spare; // program word bits 13:12
   assign hi = fetch_word[9:6];
   assign mid = fetch_word[5:2];
   assign cls0 = fetch_word[1:0] == 2'h0;
   assign spare = fetch_word[13:12];
   //------------------------------------------------------------------------------
   // instruction classes
   //------------------------------------------------------------------------------
   logic rf_ctl; // always re-fetched
   logic rf_reg; // re-fetched when target is a peripheral
   logic norm_only; // normal speed, no replay
   logic is_cmd; // speed command instruction
   logic auto_norm; // forced normal by its opcode
   logic refetch_hit; // replay starts this fetch
   assign rf_ctl = cls0 & (
      (mid == 4'h0 & hi != 4'h0) |
      (mid == 4'h1 & hi == 4'h7) |
      (mid == 4'h2 & hi == 4'h7) |
      (mid == 4'h3 & hi == 4'h7) |
      (mid == 4'h5 & hi == 4'h7) |
      (mid == 4'h6 & hi[1:0] == 2'h0) |
      (mid == 4'h7 & hi == 4'h7) |
      (mid == 4'h8 & (hi == 4'h1 | hi == 4'hB | hi == 4'hC)) |
      (mid == 4'h9) | (mid == 4'hB) | (mid == 4'hD) |
      (mid == 4'hC & (hi == 4'h0 | hi == 4'hA | hi == 4'hF)) |
      (mid == 4'hF & (hi == 4'h7 | hi == 4'hF)));
   assign rf_reg = cls0 & periph_reg &
      (mid == 4'hE | mid == 4'hA | (mid == 4'hC & hi == 4'hB));
   assign norm_only = cls0 & (
      (mid == 4'h2 & hi == 4'hF) | (mid == 4'h3 & hi == 4'hF) |
      (mid == 4'h6 & (hi == 4'h9 | hi == 4'hA | hi == 4'hB)) |
      (mid == 4'h8 & hi == 4'h8) | (mid == 4'hC & hi == 4'h8));
   assign is_cmd = cls0 & mid == 4'hF & hi == 4'h7;
   assign auto_norm = rf_ctl | rf_reg | norm_only;
   // spare bit 13 replays unless auto
   assign refetch_hit = fetch_valid & (rf_ctl | rf_reg | (!auto_norm & spare[1]));
   //------------------------------------------------------------------------------
   // speed selection
   //------------------------------------------------------------------------------
   stc_speed_t spd_q; // selected core speed
   stc_speed_t spd_d;
   logic cmd_ok; // command value in 8..D
   logic sw_wr_ctl; // software writes control register
   logic [3:0] new_cmd; // command chosen this cycle
   logic cmd_take; // a command is applied
   // nibble four on a command fetch, else write data bits 3:0, reaches the decoder
   assign new_cmd = (fetch_valid & is_cmd) ? cmd_nibble : s_axi_wdata[3:0];
   assign cmd_take = (fetch_valid & is_cmd) | sw_wr_ctl;
   assign cmd_ok = new_cmd >= `STC_CMD_N50 & new_cmd <= `STC_CMD_N1;
   assign spd_d = (cmd_take & cmd_ok) ? stc_speed_t'(3'(new_cmd - `STC_CMD_N50)) : spd_q;
   // selection register; power-down drops turbo
   always_ff @(posedge aclk) begin
      if (!aresetn | power_down) begin
         spd_q <= SPD_N50;
      end else begin
         spd_q <= spd_d;
      end
   end
   //------------------------------------------------------------------------------
   // normal speed forcing
   //------------------------------------------------------------------------------
   logic slow_q; // current instruction and next fetch at normal rate
   logic slow_d;
   assign slow_d = fetch_valid ? (!fetch_internal | auto_norm | spare != 2'h0) : slow_q;
   // forcing flag, decided anew at every fetch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_q <= 1'b0;
      end else begin
         slow_q <= slow_d;
      end
   end
   //------------------------------------------------------------------------------
   // rate generators
   //------------------------------------------------------------------------------
   stc_rate_if bus_rate ();
   stc_rate_if core_rate ();
   logic [7:0] sel_div2; // divider of selected speed
   always_comb begin
      case (spd_q)
         SPD_N50: sel_div2 = `STC_DIV2_N50;
         SPD_N25: sel_div2 = `STC_DIV2_N25;
         SPD_N10: sel_div2 = `STC_DIV2_N10;
         SPD_N5: sel_div2 = `STC_DIV2_N5;
         SPD_N2P5: sel_div2 = `STC_DIV2_N2P5;
         SPD_N1: sel_div2 = `STC_DIV2_N1;
         default: sel_div2 = `STC_DIV2_N50;
      endcase
   end
   assign bus_rate.div2 = `STC_DIV2_N50;
   assign core_rate.div2 = slow_q ? `STC_DIV2_N50 : sel_div2;
   stc_rate_gen u_bus_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .rate(bus_rate.gen)
   );
   stc_rate_gen u_core_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .rate(core_rate.gen)
   );
   assign bus_ce = bus_rate.tick;
   assign core_ce = core_rate.tick & !core_halt;
   //------------------------------------------------------------------------------
   // bus slot counter and replay sequencer
   //------------------------------------------------------------------------------
   logic [7:0] slot_q; // bus ticks into current slot
   logic slot_end; // last tick of a slot
   stc_rep_t rep_q; // replay state
   stc_rep_t rep_d;
   assign slot_end = bus_ce & slot_q == 8'(SLOT_TICKS - 1);
   // slot counter runs free at bus rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_q <= 8'h00;
      end else if (bus_ce) begin
         slot_q <= slot_end ? 8'h00 : slot_q + 8'h01;
      end
   end
   // align, show this word, show next word
   always_comb begin
      rep_d = rep_q;
      case (rep_q)
         REP_IDLE: if (refetch_hit) rep_d = REP_ALIGN;
         REP_ALIGN: if (slot_end) rep_d = REP_THIS;
         REP_THIS: if (slot_end) rep_d = REP_NEXT;
         REP_NEXT: if (slot_end) rep_d = REP_IDLE;
         default: rep_d = REP_IDLE;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rep_q <= REP_IDLE;
      end else begin
         rep_q <= rep_d;
      end
   end
   assign core_halt = rep_q != REP_IDLE;
   assign bus_word_sel = rep_q == REP_THIS ? BUS_THIS :
      (rep_q == REP_NEXT ? BUS_NEXT : BUS_NOP);
   //------------------------------------------------------------------------------
   // axi4-lite slave
   //------------------------------------------------------------------------------
   logic wr_go; // write address and data taken
   logic wr_ctl_hit; // write hits control
   logic rd_go; // read address taken
   logic [31:0] rd_val; // read mux
   logic rd_hit; // read address mapped
   assign wr_go = s_axi_awvalid & s_axi_wvalid & !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign wr_ctl_hit = s_axi_awaddr == `STC_CTRL_OFS;
   assign sw_wr_ctl = wr_go & wr_ctl_hit & s_axi_wstrb[0];
   assign rd_go = s_axi_arvalid & !s_axi_rvalid;
   assign s_axi_arready = rd_go;
   assign rd_hit = s_axi_araddr == `STC_CTRL_OFS | s_axi_araddr == `STC_STAT_OFS;
   assign rd_val = s_axi_araddr == `STC_CTRL_OFS ? {28'h0000000, 4'(spd_q) + `STC_CMD_N50} :
      (s_axi_araddr == `STC_STAT_OFS ?
      {26'h0, core_halt, slow_q, 1'b0, spd_q} : 32'h00000000);
   // write response; status register is read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `STC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ctl_hit ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // read data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `STC_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   //------------------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] bus_gap_q; // cycles since last bus tick
   logic bus_seen_q; // a bus tick has occurred
   logic [7:0] core_gap_q; // cycles since last core tick
   // helper gap counters
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_gap_q <= 8'h00;
         bus_seen_q <= 1'b0;
         core_gap_q <= 8'h00;
      end else begin
         bus_gap_q <= bus_ce ? 8'h00 : bus_gap_q + 8'h01;
         bus_seen_q <= bus_seen_q | bus_ce;
         core_gap_q <= core_rate.tick ? 8'h00 : core_gap_q + 8'h01;
      end
   end
   property p_bus_fifty;
      bus_ce & bus_seen_q |-> bus_gap_q == 8'h31;
   endproperty
   a_bus_fifty: assert property (p_bus_fifty)
      else $error("bus tick spacing not fifty");
   property p_pd_normal;
      power_down |=> spd_q == SPD_N50 && sel_div2 == `STC_DIV2_N50;
   endproperty
   a_pd_normal: assert property (p_pd_normal)
      else $error("power-down left turbo selected");
   property p_cmd_fast;
      fetch_valid & is_cmd & cmd_nibble == 4'hB & !power_down |=> spd_q == SPD_N5;
   endproperty
   a_cmd_fast: assert property (p_cmd_fast)
      else $error("command B did not select divide by five");
   property p_cmd_bad;
      fetch_valid & is_cmd & !cmd_ok & !power_down |=> $stable(spd_q);
   endproperty
   a_cmd_bad: assert property (p_cmd_bad)
      else $error("invalid command changed speed");
   property p_ext_slow;
      fetch_valid & !fetch_internal |=> slow_q && core_rate.div2 == `STC_DIV2_N50;
   endproperty
   a_ext_slow: assert property (p_ext_slow)
      else $error("external fetch not at normal speed");
   property p_replay;
      refetch_hit & !core_halt |=> core_halt && bus_word_sel == BUS_NOP;
   endproperty
   a_replay: assert property (p_replay)
      else $error("replay did not halt core");
   property p_show_next;
      rep_q == REP_THIS & slot_end |=> bus_word_sel == BUS_NEXT && !core_ce;
   endproperty
   a_show_next: assert property (p_show_next)
      else $error("next word not shown after replay word");
   property p_norm_only;
      fetch_valid & norm_only & !core_halt |=> slow_q && !core_halt;
   endproperty
   a_norm_only: assert property (p_norm_only)
      else $error("keyboard instruction replayed or fast");
   property p_clean;
      fetch_valid & fetch_internal & !auto_norm & spare == 2'h0 |=> !slow_q;
   endproperty
   a_clean: assert property (p_clean)
      else $error("clean fetch did not release normal forcing");
   property p_half;
      core_rate.tick & $past(core_rate.div2) == `STC_DIV2_N2P5 &
         $past(core_rate.div2, 4) == `STC_DIV2_N2P5 &
         core_rate.div2 == `STC_DIV2_N2P5 |-> core_gap_q == 8'h01 || core_gap_q == 8'h02;
   endproperty
   a_half: assert property (p_half)
      else $error("divide by 2.5 gap wrong");
   c_replay: cover property (rep_q == REP_NEXT & slot_end);
   c_full: cover property (spd_q == SPD_N1 & !slow_q & core_ce);
   c_half: cover property (spd_q == SPD_N2P5 & core_ce);
endmodule
`default_nettype wire

// *** stc_bus_observer.sv ***
// stc_bus_observer.sv: peripheral model that watches the serial instruction bus
`timescale 1ns/1ps
`default_nettype none
module stc_bus_observer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // serial bus as a peripheral sees it
   input wire logic bus_ce,
   input wire logic core_halt,
   input wire stc_pkg::stc_bus_sel_t bus_word_sel,
   input wire logic clr,
   // counts of observed bus words
   output logic [15:0] this_cnt,
   output logic [15:0] next_cnt,
   output logic [15:0] stray_cnt
);
   import stc_pkg::*;
   //---------------------------------------------------------------
   // bus word counters
   //---------------------------------------------------------------
   // count replayed words and stray words
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         this_cnt <= 16'h0000;
         next_cnt <= 16'h0000;
         stray_cnt <= 16'h0000;
      end else if (bus_ce) begin
         // a peripheral latches one word per bus tick
         if (bus_word_sel == BUS_THIS) this_cnt <= this_cnt + 16'h0001;
         if (bus_word_sel == BUS_NEXT) next_cnt <= next_cnt + 16'h0001;
         // running core must show only no-op fetches
         if (!core_halt && bus_word_sel != BUS_NOP) stray_cnt <= stray_cnt + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// *** speed_throttle_control_tb.sv ***
// speed_throttle_control_tb.sv: self-checking bench of the speed throttle
`timescale 1ns/1ps
`default_nettype none
`include "stc_regs.svh"
module speed_throttle_control_tb;
   import stc_pkg::*;
   //---------------------------------------------------------------
   // signals
   //---------------------------------------------------------------
   localparam int SLOT = 4; // shortened bus slot
   localparam logic [7:0] CT = `STC_CTRL_OFS;
   localparam logic [7:0] ST = `STC_STAT_OFS;
   localparam logic [1:0] OK = `STC_RESP_OKAY;
   localparam logic [1:0] ER = `STC_RESP_SLVERR;
   localparam logic [7:0] DIV2 [6] = '{`STC_DIV2_N50, `STC_DIV2_N25, `STC_DIV2_N10,
      `STC_DIV2_N5, `STC_DIV2_N2P5, `STC_DIV2_N1};
   // opcode table: periph, halt, slow, program word
   localparam logic [18:0] TBL [22] = '{19'h30040, 19'h30100, 19'h30080, 19'h30060,
      19'h302E0, 19'h30320, 19'h30024, 19'h3002C, 19'h302B0, 19'h303F0, 19'h303FC,
      19'h123C8, 19'h123CC, 19'h12258, 19'h12298, 19'h122D8, 19'h12220, 19'h12230,
      19'h70038, 19'h00038, 19'h703B8, 19'h00028};
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, cmd_nibble = 4'h0;
   logic [1:0] bresp, rresp;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, core_ce, bus_ce, core_halt;
   logic fetch_valid = 1'b0, fetch_internal = 1'b0, periph_reg = 1'b0, power_down = 1'b0;
   logic [15:0] fetch_word = 16'h0000, this_cnt, next_cnt, stray_cnt;
   stc_bus_sel_t bus_word_sel;
   int error_cnt = 0, comparisons = 0;
   // 20 MHz clock
   always #25 aclk = ~aclk;
   //---------------------------------------------------------------
   // design and bus observer
   //---------------------------------------------------------------
   stc_top #(.SLOT_TICKS(SLOT)) stc_top_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_internal(fetch_internal),
      .periph_reg(periph_reg), .cmd_nibble(cmd_nibble), .power_down(power_down),
      .core_ce(core_ce), .bus_ce(bus_ce), .core_halt(core_halt), .bus_word_sel(bus_word_sel));
   stc_bus_observer stc_bus_observer_inst (.aclk(aclk), .aresetn(aresetn), .bus_ce(bus_ce),
      .core_halt(core_halt), .bus_word_sel(bus_word_sel), .clr(fetch_valid),
      .this_cnt(this_cnt), .next_cnt(next_cnt), .stray_cnt(stray_cnt));
   //---------------------------------------------------------------
   // reporting and comparison
   //---------------------------------------------------------------
   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic give_up();
      error_cnt++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   //---------------------------------------------------------------
   // axi4-lite master tasks
   //---------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // both channels are taken together
      for (n = 0; n < 100 && !(awready === 1'b1 && wready === 1'b1); n++) @(negedge aclk);
      if (n == 100) give_up();
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      for (n = 0; n < 100 && bvalid !== 1'b1; n++) @(negedge aclk);
      if (n == 100) give_up();
      chk_word({30'h0, bresp}, {30'h0, er}, "write response");
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100 && arready !== 1'b1; n++) @(negedge aclk);
      if (n == 100) give_up();
      @(posedge aclk);
      arvalid <= 1'b0;
      for (n = 0; n < 100 && rvalid !== 1'b1; n++) @(negedge aclk);
      if (n == 100) give_up();
      chk_word(rdata, ed, "read data");
      chk_word({30'h0, rresp}, {30'h0, er}, "read response");
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   //---------------------------------------------------------------
   // fetch port and rate measurement
   //---------------------------------------------------------------
   // one fetch right after a core enable, halt looked at next cycle
   task automatic fetch(input logic [15:0] w, input logic in, input logic pr,
         input logic [3:0] nb, input logic eh);
      int n;
      for (n = 0; n < 200 && !(core_ce === 1'b1 && core_halt === 1'b0); n++) @(negedge aclk);
      if (n == 200) give_up();
      @(posedge aclk);
      fetch_valid <= 1'b1;
      fetch_word <= w;
      fetch_internal <= in;
      periph_reg <= pr;
      cmd_nibble <= nb;
      @(posedge aclk);
      fetch_valid <= 1'b0;
      #1;
      chk_word({31'h0, core_halt}, {31'h0, eh}, "halt after fetch");
   endtask
   // wait out a replay, then check the words peripherals saw
   task automatic replay_end();
      int n;
      for (n = 0; n < 5000 && core_halt !== 1'b0; n++) @(negedge aclk);
      if (n == 5000) give_up();
      chk_word({16'h0, this_cnt}, SLOT, "replayed word ticks");
      chk_word({16'h0, next_cnt}, SLOT, "following word ticks");
      chk_word({16'h0, stray_cnt}, 32'h0, "stray bus words");
   endtask
   // count enables over 100 cycles, after settling
   task automatic rate(input int ec);
      int nc, nb, gap, prev;
      nc = 0;
      nb = 0;
      gap = 0;
      prev = 0;
      repeat (60) @(posedge aclk);
      repeat (100) begin
         @(posedge aclk);
         #1;
         gap++;
         if (core_ce === 1'b1) begin
            nc++;
            if (nc > 2 && ec == 40) chk_word(32'(gap + prev), 32'd5, "gap pair");
            prev = gap;
            gap = 0;
         end
         if (bus_ce === 1'b1) nb++;
      end
      chk_word(32'(nc), 32'(ec), "core enables");
      chk_word(32'(nb), 32'd2, "bus enables");
   endtask
   //---------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(CT, 32'h8, OK);
      rd_chk(ST, 32'h0, OK);
      rate(2);
      for (int i = 0; i < 6; i++) begin
         axi_wr(CT, 32'(`STC_CMD_N50 + i), OK);
         rd_chk(ST, 32'(i), OK);
         rate(200 / int'(DIV2[i]));
      end
      axi_wr(CT, 32'h3, OK);
      rd_chk(CT, 32'hD, OK);
      axi_wr(ST, 32'h0, ER);
      rd_chk(8'h08, 32'h0, ER);
      fetch(16'h0002, 1'b0, 1'b0, 4'h0, 1'b0);
      rd_chk(ST, 32'h15, OK);
      rate(2);
      fetch(16'h0002, 1'b1, 1'b0, 4'h0, 1'b0);
      rd_chk(ST, 32'h05, OK);
      rate(100);
      fetch(16'h2002, 1'b1, 1'b0, 4'h0, 1'b1);
      rd_chk(ST, 32'h35, OK);
      replay_end();
      // bit 13 above, bit 12 on this fetch, then a clean fetch
      fetch(16'h1002, 1'b1, 1'b0, 4'h0, 1'b0);
      rd_chk(ST, 32'h15, OK);
      fetch(16'h0002, 1'b1, 1'b0, 4'h0, 1'b0);
      rd_chk(ST, 32'h05, OK);
      foreach (TBL[i]) begin
         fetch(TBL[i][15:0], 1'b1, TBL[i][18], 4'h0, TBL[i][17]);
         rd_chk(ST, {26'h0, TBL[i][17], TBL[i][16], 4'h5}, OK);
         if (TBL[i][17]) replay_end();
      end
      fetch(16'h01FC, 1'b1, 1'b0, 4'hB, 1'b1);
      replay_end();
      rd_chk(CT, 32'hB, OK);
      fetch(16'h01FC, 1'b1, 1'b0, 4'h2, 1'b1);
      replay_end();
      rd_chk(CT, 32'hB, OK);
      @(posedge aclk);
      power_down <= 1'b1;
      repeat (3) @(posedge aclk);
      power_down <= 1'b0;
      rd_chk(CT, 32'h8, OK);
      axi_wr(CT, 32'hD, OK);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(CT, 32'h8, OK);
      stop_test();
   end
endmodule
`default_nettype wire
